// ==== logic/srn_pkg.sv ====
// constants and state codes for the run-sequencer command interpreter
// How it works
// - code 33h selects the run-sequencer operation
// - start address is high bit plus low byte
// - nine-bit length, zero means 512 bytes
// - zero length with nonzero address returns 77h
// - address plus length over 512 aborts, 77h
// - power-on flag set blocks execution, returns 44h
// - execution starts only after the release byte
// - 55h malformed, 77h invalid, AAh success
// - I2C NACK returns 88h plus two offset bytes
// - offset nine bits, high bit in bit 0
// - offset value zero stands for offset 512
// - offset bytes only in I2C mode after NACK
// - length bits from second and third parameter bytes
// - frame is 66h, 4, command, three params, release
package srn_pkg;
  localparam logic [7:0] SRN_CMD_START = 8'h66;
  localparam logic [7:0] SRN_CMD_LEN = 8'h04;
  localparam logic [7:0] SRN_CMD_RUN = 8'h33;
  localparam logic [7:0] SRN_RELEASE = 8'haa;
  localparam logic [7:0] SRN_RES_POR = 8'h44;
  localparam logic [7:0] SRN_RES_MALFORMED = 8'h55;
  localparam logic [7:0] SRN_RES_INVALID = 8'h77;
  localparam logic [7:0] SRN_RES_NACK = 8'h88;
  localparam logic [7:0] SRN_RES_OK = 8'haa;
  localparam logic [7:0] SRN_RESP_LEN_SHORT = 8'h01;
  localparam logic [7:0] SRN_RESP_LEN_NACK = 8'h03;
  localparam int SRN_ADDR_W = 9;
  localparam int SRN_LEN_W = 10;
  localparam logic [9:0] SRN_MEM_SIZE = 10'h200;
  localparam int SRN_START_ADDR_HIGH_BIT_BIT = 0;
  localparam int SRN_LEN_LO_MSB = 7;
  localparam int SRN_LEN_LO_LSB = 1;
  localparam int SRN_LEN_HI_MSB = 1;
  localparam int SRN_LEN_HI_LSB = 0;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_LEN  = 9'h002,
    ST_CMD  = 9'h004,
    ST_P1   = 9'h008,
    ST_P2   = 9'h010,
    ST_P3   = 9'h020,
    ST_REL  = 9'h040,
    ST_RUN  = 9'h080,
    ST_RESP = 9'h100
  } srn_state_t;
endpackage

// ==== logic/srn_range_check.sv ====
// decodes start address and length from the parameter bytes and checks the range
`timescale 1ns/10ps
`default_nettype none
module srn_range_check
  import srn_pkg::*;
(
  input wire logic [7:0] param1, // start_addr_low
  input wire logic [7:0] param2, // exec_length_low and start_addr_high_bit
  input wire logic [7:0] param3, // exec_length_high in low bits
  output logic [SRN_ADDR_W-1:0] start_addr, // decoded start address
  output logic [SRN_LEN_W-1:0] exec_len, // byte count, 1 to 512
  output logic range_err // request is invalid
);
  logic [8:0] len_raw;
  logic [SRN_LEN_W:0] range_end;

  // address and length assembly, reserved bits of param3 never read
  assign start_addr = {param2[SRN_START_ADDR_HIGH_BIT_BIT], param1};
  assign len_raw = {param3[SRN_LEN_HI_MSB:SRN_LEN_HI_LSB],
                    param2[SRN_LEN_LO_MSB:SRN_LEN_LO_LSB]};
  assign exec_len = (len_raw == 9'h000) ? SRN_MEM_SIZE : {1'b0, len_raw};
  // range end checked one bit wider so 511 + 512 cannot wrap
  assign range_end = {2'b00, start_addr} + {1'b0, exec_len};
  assign range_err = ((len_raw == 9'h000) && (start_addr != 9'h000))
                   || (range_end > {1'b0, SRN_MEM_SIZE});
endmodule // srn_range_check
`default_nettype wire

// ==== logic/srn_run_cmd.sv ====
// run-sequencer command interpreter: frame parse, checks, launch, result
`timescale 1ns/10ps
`default_nettype none
module srn_run_cmd
  import srn_pkg::*;
(
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic bus_reset, // link reset pulse, aborts a frame being parsed
  input wire logic rx_valid, // one-cycle strobe, byte received from host
  input wire logic [7:0] rx_data, // received byte
  input wire logic por_flag, // power-on-reset status flag, level
  input wire logic i2c_mode, // high when configured for I2C
  input wire logic seq_done, // one-cycle pulse, sequencer finished
  input wire logic seq_malformed, // with seq_done: packets malformed
  input wire logic seq_nack, // with seq_done: I2C data byte not acknowledged
  input wire logic [SRN_LEN_W-1:0] seq_nack_offset, // with seq_done: offset 1 to 512
  input wire logic resp_ack, // one-cycle pulse, response sent to host
  output logic seq_start, // one-cycle pulse, start executing packets
  output logic [SRN_ADDR_W-1:0] seq_addr, // start address for the sequencer
  output logic [SRN_LEN_W-1:0] seq_len, // byte count for the sequencer
  output logic busy, // command accepted and not yet answered
  output logic resp_valid, // response bytes ready, level until resp_ack or a link reset
  output logic [7:0] resp_length, // response length byte, 1 or 3
  output logic [7:0] resp_result, // result byte
  output logic [7:0] nack_offset_low, // low offset byte
  output logic [7:0] nack_offset_high_bit // offset bit 8 in bit 0
);
  srn_state_t state_q, state_d;
  logic [7:0] p1_q, p2_q, p3_q;
  logic seq_start_q;
  logic [SRN_ADDR_W-1:0] seq_addr_q;
  logic [SRN_LEN_W-1:0] seq_len_q;
  logic resp_valid_q;
  logic [7:0] resp_length_q, resp_result_q, nack_low_q, nack_high_q;
  logic [SRN_ADDR_W-1:0] chk_addr;
  logic [SRN_LEN_W-1:0] chk_len;
  logic chk_err;
  logic got_release, launch, refuse, nack_hit, byte_ok;
  logic [7:0] expect_byte, refuse_code, done_code;

  srn_range_check u_check (
    .param1(p1_q),
    .param2(p2_q),
    .param3(p3_q),
    .start_addr(chk_addr),
    .exec_len(chk_len),
    .range_err(chk_err)
  );

  // decode of the incoming byte against the frame position
  assign expect_byte = (state_q == ST_IDLE) ? SRN_CMD_START :
                       (state_q == ST_LEN) ? SRN_CMD_LEN : SRN_CMD_RUN;
  assign byte_ok = rx_valid && (rx_data == expect_byte);
  // a link reset in the release cycle aborts the frame, so nothing launches or answers
  assign got_release = (state_q == ST_REL) && rx_valid && (rx_data == SRN_RELEASE)
                       && !bus_reset;
  assign refuse = por_flag || chk_err;
  assign refuse_code = por_flag ? SRN_RES_POR : SRN_RES_INVALID;
  assign launch = got_release && !refuse;
  assign nack_hit = seq_nack && i2c_mode;
  assign done_code = seq_malformed ? SRN_RES_MALFORMED :
                     nack_hit ? SRN_RES_NACK : SRN_RES_OK;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE, ST_LEN, ST_CMD: begin
        if (rx_valid) begin
          state_d = byte_ok ? srn_state_t'(state_q << 1) : ST_IDLE;
        end
      end
      ST_P1: if (rx_valid) state_d = ST_P2;
      ST_P2: if (rx_valid) state_d = ST_P3;
      ST_P3: if (rx_valid) state_d = ST_REL;
      ST_REL: begin
        if (rx_valid) begin
          state_d = !got_release ? ST_IDLE : (refuse ? ST_RESP : ST_RUN);
        end
      end
      ST_RUN: if (seq_done) state_d = ST_RESP;
      ST_RESP: if (resp_ack) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    if (bus_reset && (state_q != ST_RUN)) begin
      state_d = ST_IDLE;
    end
  end

  // state and parameter capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      p3_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (rx_valid && (state_q == ST_P1)) p1_q <= rx_data;
      if (rx_valid && (state_q == ST_P2)) p2_q <= rx_data;
      if (rx_valid && (state_q == ST_P3)) p3_q <= rx_data;
    end
  end

  // sequencer launch, only after release and a clean check
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_start_q <= 1'b0;
      seq_addr_q <= 9'h000;
      seq_len_q <= 10'h000;
    end else begin
      seq_start_q <= launch;
      if (launch) begin
        seq_addr_q <= chk_addr;
        seq_len_q <= chk_len;
      end
    end
  end

  // response bytes, held until the link has sent them or a link reset outside ST_RUN drops them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_length_q <= 8'h00;
      resp_result_q <= 8'h00;
      nack_low_q <= 8'h00;
      nack_high_q <= 8'h00;
    end else if (got_release && refuse) begin
      resp_valid_q <= 1'b1;
      resp_length_q <= SRN_RESP_LEN_SHORT;
      resp_result_q <= refuse_code;
    end else if ((state_q == ST_RUN) && seq_done) begin
      resp_valid_q <= 1'b1;
      resp_result_q <= done_code;
      resp_length_q <= (done_code == SRN_RES_NACK) ?
                       SRN_RESP_LEN_NACK : SRN_RESP_LEN_SHORT;
      nack_low_q <= seq_nack_offset[7:0];
      nack_high_q <= {7'h00, seq_nack_offset[8]};
    end else if (resp_ack || (bus_reset && (state_q != ST_RUN))) begin
      resp_valid_q <= 1'b0;
    end
  end

  // outputs
  assign seq_start = seq_start_q;
  assign seq_addr = seq_addr_q;
  assign seq_len = seq_len_q;
  assign busy = (state_q == ST_RUN) || (state_q == ST_RESP);
  assign resp_valid = resp_valid_q;
  assign resp_length = resp_length_q;
  assign resp_result = resp_result_q;
  assign nack_offset_low = nack_low_q;
  assign nack_offset_high_bit = nack_high_q;

  // checks on the command behaviour
  a_start_needs_release: assert property (@(posedge sys_clk) disable iff (rst)
    seq_start |-> $past(state_q) == ST_REL && $past(rx_valid) && $past(rx_data) == SRN_RELEASE)
    else $error("sequencer started without release byte");
  a_por_blocks_run: assert property (@(posedge sys_clk) disable iff (rst)
    got_release && por_flag |=> !seq_start && resp_valid && resp_result == SRN_RES_POR)
    else $error("power-on flag did not block execution");
  a_zero_len_err: assert property (@(posedge sys_clk) disable iff (rst)
    got_release && !por_flag && {p3_q[1:0], p2_q[7:1]} == 9'h000 && {p2_q[0], p1_q} != 9'h000
    |=> !seq_start && resp_result == SRN_RES_INVALID)
    else $error("zero length with nonzero address not refused");
  a_range_in_mem: assert property (@(posedge sys_clk) disable iff (rst)
    seq_start |-> ({1'b0, seq_len} + {2'b00, seq_addr}) <= 11'h200 && seq_len != 10'h000)
    else $error("launched range leaves sequencer memory");
  a_len_decode: assert property (@(posedge sys_clk) disable iff (rst)
    seq_start |-> seq_len == (({p3_q[1:0], p2_q[7:1]} == 9'h000) ? 10'h200
                              : {1'b0, p3_q[1:0], p2_q[7:1]}))
    else $error("length decode wrong");
  a_addr_decode: assert property (@(posedge sys_clk) disable iff (rst)
    seq_start |-> seq_addr == {p2_q[0], p1_q})
    else $error("address decode wrong");
  a_bad_cmd_drop: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == ST_CMD && rx_valid && rx_data != SRN_CMD_RUN |=> state_q == ST_IDLE)
    else $error("wrong command code accepted");
  a_done_malformed: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == ST_RUN && seq_done && seq_malformed |=> resp_result == SRN_RES_MALFORMED)
    else $error("malformed packets not reported");
  a_nack_three: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == ST_RUN && seq_done && !seq_malformed && seq_nack && i2c_mode
    |=> resp_result == SRN_RES_NACK && resp_length == SRN_RESP_LEN_NACK
        && {nack_offset_high_bit[0], nack_offset_low} == $past(seq_nack_offset[8:0]))
    else $error("nack response wrong");
  a_spi_no_offset: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == ST_RUN && seq_done && !i2c_mode
    |=> resp_length == SRN_RESP_LEN_SHORT && resp_result != SRN_RES_NACK)
    else $error("offset bytes sent without nack");
  a_high_reserved: assert property (@(posedge sys_clk) disable iff (rst)
    nack_offset_high_bit[7:1] == 7'h00)
    else $error("reserved offset bits not zero");

  c_run_ok: cover property (@(posedge sys_clk) disable iff (rst)
    resp_valid && resp_result == SRN_RES_OK);
  c_run_nack: cover property (@(posedge sys_clk) disable iff (rst)
    resp_valid && resp_result == SRN_RES_NACK);
  c_run_por: cover property (@(posedge sys_clk) disable iff (rst)
    resp_valid && resp_result == SRN_RES_POR);
endmodule // srn_run_cmd
`default_nettype wire

// ==== testbench/srn_seq_model.sv ====
// sequencer and response-reader model facing the run-sequencer interpreter
`timescale 1ns/10ps
`default_nettype none
module srn_seq_model (
  input wire logic sys_clk, // clock
  input wire logic rst, // synchronous reset
  input wire logic seq_start, // launch pulse from the interpreter
  input wire logic resp_valid, // response ready
  input wire logic [7:0] run_cyc, // run duration in cycles
  input wire logic want_mal, // outcome: packets malformed
  input wire logic want_nack, // outcome: data byte not acknowledged
  input wire logic [9:0] want_off, // outcome: nack offset
  output logic seq_done, // end of run pulse
  output logic seq_malformed, // qualifier of seq_done
  output logic seq_nack, // qualifier of seq_done
  output logic [9:0] seq_nack_offset, // qualifier of seq_done
  output logic resp_ack // response read pulse
);
  logic [8:0] run_q;
  logic [2:0] ack_q;
  logic strong_pullup;
  // run timer; qualifiers toggle outside the done pulse so stale values never match
  // the launched range is not modelled, the outcome comes from the bench
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_q <= '0;
      seq_done <= 1'b0;
      seq_malformed <= 1'b0;
      seq_nack <= 1'b0;
      seq_nack_offset <= '0;
    end else begin
      run_q <= seq_start ? {1'b0, run_cyc} + 9'h002 : (run_q != 9'h000 ? run_q - 9'h001 : run_q);
      seq_done <= (run_q == 9'h001);
      seq_malformed <= (run_q == 9'h001) ? want_mal : ~seq_malformed;
      seq_nack <= (run_q == 9'h001) ? want_nack : ~seq_nack;
      seq_nack_offset <= (run_q == 9'h001) ? want_off : ~seq_nack_offset;
    end
  end
  // host pullup: on from launch or refusal until the reader acks the response
  always_ff @(posedge sys_clk) begin
    if (rst || resp_ack) begin
      strong_pullup <= 1'b0;
    end else if (seq_start || resp_valid) begin
      strong_pullup <= 1'b1;
    end
  end
  // the reader takes the response a few cycles after it appears, then acks once
  always_ff @(posedge sys_clk) begin
    if (rst || !resp_valid) begin
      ack_q <= '0;
    end else if (ack_q != 3'h7) begin
      ack_q <= ack_q + 3'h1;
    end
    resp_ack <= !rst && resp_valid && strong_pullup && (ack_q == 3'h3);
  end
endmodule // srn_seq_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the run-sequencer command interpreter
`timescale 1ns/10ps
`default_nettype none
module testbench
  import srn_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, bus_reset = 1'b0, rx_valid = 1'b0;
  logic por_flag = 1'b0, i2c_mode = 1'b0, want_mal = 1'b0, want_nack = 1'b0;
  logic [7:0] rx_data = 8'h00, run_cyc = 8'h00;
  logic [9:0] want_off = 10'h000, seq_nack_offset, seq_len;
  logic seq_done, seq_malformed, seq_nack, resp_ack, seq_start, busy, resp_valid;
  logic [8:0] seq_addr;
  logic [7:0] resp_length, resp_result, nack_offset_low, nack_offset_high_bit;
  logic [31:0] rs = 32'd42;
  logic [23:0] edge_tab [6] = '{24'h000000, 24'h010000, 24'h000102, 24'h0003fe, 24'hffffff,
    24'hff0300};
  int fails, n_tests, cyc, starts, n;

  srn_run_cmd uut (.sys_clk, .rst, .bus_reset, .rx_valid, .rx_data, .por_flag, .i2c_mode,
    .seq_done, .seq_malformed, .seq_nack, .seq_nack_offset, .resp_ack, .seq_start, .seq_addr,
    .seq_len, .busy, .resp_valid, .resp_length, .resp_result, .nack_offset_low,
    .nack_offset_high_bit);
  srn_seq_model pm (.sys_clk, .rst, .seq_start, .resp_valid, .run_cyc, .want_mal, .want_nack,
    .want_off, .seq_done, .seq_malformed, .seq_nack, .seq_nack_offset, .resp_ack);

  // 250 MHz clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // launch counter and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (seq_start === 1'b1) starts++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one whole frame, bytes back to back
  task automatic send(input logic [7:0] cmd, p1, p2, p3, rel);
    logic [7:0] q[$];
    q = {SRN_CMD_START, SRN_CMD_LEN, cmd, p1, p2, p3, rel};
    foreach (q[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask

  // one run command with random status and outcome, checked against the integer model
  task automatic run_case(input logic [7:0] p1, p2, p3);
    int addr, rlen, len, exp;
    logic por, i2c, mal, nk, go;
    logic [9:0] off;
    addr = {p2[0], p1};
    rlen = {p3[1:0], p2[7:1]};
    len = (rlen == 0) ? 512 : rlen;
    por = (xs() % 8 == 0);
    i2c = (xs() % 2 == 1);
    mal = (xs() % 4 == 0);
    nk = (xs() % 2 == 1);
    off = (xs() % 8 == 0) ? 10'h200 : 10'(xs() % 511 + 1);
    exp = por ? 'h44 : ((rlen == 0 && addr != 0) || addr + len > 512) ? 'h77 :
      mal ? 'h55 : (nk && i2c) ? 'h88 : 'haa;
    go = (exp != 'h44 && exp != 'h77);
    @(posedge sys_clk);
    por_flag <= por;
    i2c_mode <= i2c;
    want_mal <= mal;
    want_nack <= nk;
    want_off <= off;
    run_cyc <= 8'(xs() % 16);
    send(SRN_CMD_RUN, p1, p2, p3, SRN_RELEASE);
    #1;
    check(10'(seq_start), 10'(go));
    check(10'(resp_valid), 10'(!go));
    if (go) begin
      check(10'(seq_addr), 10'(addr));
      check(seq_len, 10'(len));
      check(10'(busy), 10'h001);
    end
    for (int k = 0; k < 40 && resp_valid !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    check(10'(resp_result), 10'(exp));
    check(10'(resp_length), (exp == 'h88) ? 10'h003 : 10'h001);
    if (exp == 'h88) begin
      check(10'(nack_offset_low), {2'b00, off[7:0]});
      check(10'(nack_offset_high_bit), {9'h000, off[8]});
    end
    for (int k = 0; k < 40 && resp_valid !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    check(10'(busy), 10'h000);
    $display("test done, result %h", exp[7:0]);
  endtask

  // boundary ranges first, then random frames, then frames that must launch nothing, then one valid run
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (edge_tab[i]) run_case(edge_tab[i][23:16], edge_tab[i][15:8], edge_tab[i][7:0]);
    for (int i = 0; i < 30; i++) run_case(8'(xs()), 8'(xs()), 8'(xs()));
    n = starts;
    send(8'h34, 8'h00, 8'h02, 8'h00, SRN_RELEASE);
    send(SRN_CMD_RUN, 8'h00, 8'h02, 8'h00, 8'h55);
    // link reset lands with the first parameter byte, the rest of the frame must launch nothing
    fork
      send(SRN_CMD_RUN, 8'h00, 8'h02, 8'h00, SRN_RELEASE);
      begin
        repeat (4) @(posedge sys_clk);
        bus_reset <= 1'b1;
        @(posedge sys_clk);
        bus_reset <= 1'b0;
      end
    join
    repeat (4) @(posedge sys_clk);
    #1;
    check(10'(starts), 10'(n));
    check(10'(resp_valid), 10'h000);
    $display("test done, bad frames");
    run_case(8'h10, 8'h04, 8'h00);
    results();
  end
endmodule // testbench
`default_nettype wire
